// [logic/dacoc_consts.vh]
// Purpose: shared constants of the dual converter output control block
// Assumes: 100 MHz mclk; all times in ns, counts derived from them
// Notes: definitions only, included by bare name
`ifndef DACOC_CONSTS_VH
`define DACOC_CONSTS_VH

// --------------------------------
// clock and timing
// --------------------------------
`define DACOC_CLK_MHZ 100
// one channel conversion, rounded up to whole cycles
`define DACOC_CONV_NS 700
`define DACOC_CONV_CYC ((`DACOC_CONV_NS * `DACOC_CLK_MHZ + 999) / 1000)
// impulse-mode acquisition phase, rounded up
`define DACOC_ACQ_NS 250
`define DACOC_ACQ_CYC ((`DACOC_ACQ_NS * `DACOC_CLK_MHZ + 999) / 1000)
// internal serial clock half period, rounded down
`define DACOC_SCLK_HALF_NS 20
`define DACOC_SCLK_HALF_CYC ((`DACOC_SCLK_HALF_NS * `DACOC_CLK_MHZ) / 1000)

// --------------------------------
// data layout
// --------------------------------
`define DACOC_RES_W 16
`define DACOC_WORD_BITS 6'h20
`define DACOC_HALF_BITS 6'h10
`define DACOC_FIFO_DEPTH 16
// shared pin positions on the 16-bit output bus
`define DACOC_BIT_SDO 8
`define DACOC_BIT_SCLK 9
`define DACOC_BIT_FS 10
`define DACOC_BIT_ERR 11

// --------------------------------
// reset values
// --------------------------------
// synchroniser reset: start, chip select and read idle high
`define DACOC_PIN_RST 12'h700
`define DACOC_RST_BUSY 1'b0
`define DACOC_RST_EOC_N 1'b1
`define DACOC_RST_BUS 16'h0000

`endif

// [logic/dacoc_fifo.v]
// Purpose: result buffer between conversion engine and output port
// Assumes: one clock, synchronous active-high reset
// Notes: flip-flop storage, honest full and empty
`timescale 1ns/1ns
`default_nettype none

module dacoc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16
)
(
  // clock and reset
  input wire mclk,
  input wire srst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // --------------------------------
  // handshakes
  // --------------------------------
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer wrap works for any depth, not only powers of two
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // --------------------------------
  // storage and pointers
  // --------------------------------
  always @(posedge mclk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push & ~pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // dacoc_fifo

`default_nettype wire

// [logic/dacoc_ctrl.v]
// Purpose: conversion sequencing and parallel/serial result port
// Assumes: pins sampled by mclk through two flops; core results on mclk
// Notes: the pin reset joins srst after synchronising
//
// Behaviour
// - frame sync high at read, low pulse mid
// - inverted frame sync low at read, high pulse
// - frame sync only serial internal clock, bit10 in parallel, released in slave
// - slave read overrun discards data, pulses flag
// - parallel mode: flag, sync pins carry bits 11,10
// - bits 12-15 parallel only, released in serial
// - busy from start until results enter the buffer
// - end-of-conversion low once per channel
// - bus enabled only while select and read low
// - chip select gates external serial clock
// - reset pin aborts conversion and resets
// - power-down finishes current, refuses new conversions
// - start falling edge holds and starts conversion
// - impulse mode restarts if start held low
// - 32-bit register shifted msb first, ordered
// - external clock edges chosen by clock invert
`timescale 1ns/1ns
`default_nettype none
`include "dacoc_consts.vh"

module dacoc_ctrl #(
  parameter RES_W = `DACOC_RES_W,
  parameter CONV_CYC = `DACOC_CONV_CYC,
  parameter ACQ_CYC = `DACOC_ACQ_CYC,
  parameter SCLK_HALF = `DACOC_SCLK_HALF_CYC,
  parameter FIFO_DEPTH = `DACOC_FIFO_DEPTH
)
(
  // clock and reset
  input wire mclk,
  input wire srst,
  // host control pins
  input wire convert_start_n,
  input wire cs_n,
  input wire rd_n,
  input wire reset_in,
  input wire power_down_in,
  input wire impulse_mode,
  // serial port configuration pins
  input wire serial_parallel_select,
  input wire clock_source_select,
  input wire frame_sync_invert,
  input wire serial_clock_invert,
  input wire channel_order_sel,
  // serial clock pin, input side
  input wire sclk_in,
  // results from the converter core
  input wire [RES_W-1:0] result_a,
  input wire [RES_W-1:0] result_b,
  // status outputs
  output wire busy,
  output wire eoc_n,
  // shared data bus pins
  output wire [RES_W-1:0] d_out,
  output wire [RES_W-1:0] d_oe
);

  localparam WW = 2 * RES_W;
  localparam NP = 12;
  localparam [2:0] C_IDLE = 3'd0;
  localparam [2:0] C_CH1 = 3'd1;
  localparam [2:0] C_CH2 = 3'd2;
  localparam [2:0] C_PUSH = 3'd3;
  localparam [2:0] C_ACQ = 3'd4;
  localparam [1:0] R_IDLE = 2'd0;
  localparam [1:0] R_SHIFT = 2'd1;
  localparam [1:0] R_PAR = 2'd2;
  localparam [1:0] R_DONE = 2'd3;

  // --------------------------------
  // pin synchronisers
  // --------------------------------
  wire [NP-1:0] pin_raw;
  reg [NP-1:0] pin_s1_r;
  reg [NP-1:0] pin_s2_r;
  reg [NP-1:0] pin_s3_r;

  assign pin_raw = {sclk_in, convert_start_n, cs_n, rd_n, reset_in,
                    power_down_in, serial_parallel_select, clock_source_select,
                    frame_sync_invert, serial_clock_invert, channel_order_sel,
                    impulse_mode};

  // third stage only feeds edge detection, never the first stage
  always @(posedge mclk)
  begin
    if (srst)
    begin
      pin_s1_r <= `DACOC_PIN_RST;
      pin_s2_r <= `DACOC_PIN_RST;
      pin_s3_r <= `DACOC_PIN_RST;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire sclk_s = pin_s2_r[11];
  wire cnv_n_s = pin_s2_r[10];
  wire cs_n_s = pin_s2_r[9];
  wire rd_n_s = pin_s2_r[8];
  wire pd_s = pin_s2_r[6];
  wire ser_s = pin_s2_r[5];
  wire ext_s = pin_s2_r[4];
  wire fs_inv_s = pin_s2_r[3];
  wire sck_inv_s = pin_s2_r[2];
  wire a_first_s = pin_s2_r[1];
  wire imp_s = pin_s2_r[0];
  // pin reset acts once synchronised, so it cannot glitch the state
  wire rst = srst | pin_s2_r[7];
  wire cnv_fall = pin_s3_r[10] & ~cnv_n_s;
  wire access = ~cs_n_s & ~rd_n_s;
  wire master = ser_s & ~ext_s;
  wire slave = ser_s & ext_s;
  // external clock edges are ignored while chip select is high
  wire sck_rise = ~cs_n_s & sclk_s & ~pin_s3_r[11];
  wire sck_fall = ~cs_n_s & ~sclk_s & pin_s3_r[11];
  wire upd_edge = sck_inv_s ? sck_fall : sck_rise;
  wire smp_edge = sck_inv_s ? sck_rise : sck_fall;

  // --------------------------------
  // conversion sequencer
  // --------------------------------
  reg [2:0] conv_st_r;
  reg [11:0] tmr_r;
  reg busy_r;
  reg eoc_n_r;
  reg [WW-1:0] conv_word_r;
  wire fifo_in_ready;
  wire push_evt = (conv_st_r == C_PUSH) & fifo_in_ready;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      conv_st_r <= C_IDLE;
      tmr_r <= 12'h000;
      busy_r <= `DACOC_RST_BUSY;
      eoc_n_r <= `DACOC_RST_EOC_N;
      conv_word_r <= {WW{1'b0}};
    end
    else
    begin
      eoc_n_r <= 1'b1;
      case (conv_st_r)
        C_IDLE:
        begin
          // power-down refuses new starts only; running ones finish
          if (cnv_fall & ~pd_s)
          begin
            conv_st_r <= C_CH1;
            tmr_r <= CONV_CYC[11:0] - 12'h001;
            busy_r <= 1'b1;
          end
        end
        C_CH1:
        begin
          if (tmr_r == 12'h000)
          begin
            eoc_n_r <= 1'b0;
            conv_st_r <= C_CH2;
            tmr_r <= CONV_CYC[11:0] - 12'h001;
          end
          else
          begin
            tmr_r <= tmr_r - 12'h001;
          end
        end
        C_CH2:
        begin
          if (tmr_r == 12'h000)
          begin
            eoc_n_r <= 1'b0;
            conv_st_r <= C_PUSH;
            conv_word_r <= a_first_s ? {result_a, result_b}
                                     : {result_b, result_a};
          end
          else
          begin
            tmr_r <= tmr_r - 12'h001;
          end
        end
        C_PUSH:
        begin
          // busy stays high while the buffer is full: back-pressure
          if (fifo_in_ready)
          begin
            busy_r <= 1'b0;
            if (imp_s)
            begin
              conv_st_r <= C_ACQ;
              tmr_r <= ACQ_CYC[11:0] - 12'h001;
            end
            else
            begin
              conv_st_r <= C_IDLE;
            end
          end
        end
        C_ACQ:
        begin
          if (tmr_r != 12'h000)
          begin
            tmr_r <= tmr_r - 12'h001;
          end
          else if (~cnv_n_s & ~pd_s)
          begin
            // start low when acquisition ends: convert at once
            conv_st_r <= C_CH1;
            tmr_r <= CONV_CYC[11:0] - 12'h001;
            busy_r <= 1'b1;
          end
          else
          begin
            conv_st_r <= C_IDLE;
          end
        end
        default:
        begin
          conv_st_r <= C_IDLE;
        end
      endcase
    end
  end

  // --------------------------------
  // result buffer
  // --------------------------------
  wire fifo_out_valid;
  wire [WW-1:0] fifo_out_data;
  reg have_r;

  dacoc_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(rst),
    .in_valid(conv_st_r == C_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(conv_word_r),
    .out_valid(fifo_out_valid),
    .out_ready(~have_r),
    .out_data(fifo_out_data)
  );

  // --------------------------------
  // read sequencer
  // --------------------------------
  reg [1:0] rd_st_r;
  reg [WW-1:0] word_r;
  reg [WW-1:0] sr_r;
  reg [5:0] bit_cnt_r;
  reg [7:0] half_cnt_r;
  reg sclk_int_r;
  reg gap_r;
  reg gap_ph_r;
  reg fs_act_r;
  reg err_r;
  reg par_hi_r;
  wire tog = (half_cnt_r == SCLK_HALF[7:0] - 8'h01);
  wire [5:0] cnt_inc = bit_cnt_r + 6'h01;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      rd_st_r <= R_IDLE;
      have_r <= 1'b0;
      word_r <= {WW{1'b0}};
      sr_r <= {WW{1'b0}};
      bit_cnt_r <= 6'h00;
      half_cnt_r <= 8'h00;
      sclk_int_r <= 1'b0;
      gap_r <= 1'b0;
      gap_ph_r <= 1'b0;
      fs_act_r <= 1'b0;
      err_r <= 1'b0;
      par_hi_r <= 1'b0;
    end
    else
    begin
      err_r <= 1'b0;
      if (~have_r & fifo_out_valid)
      begin
        have_r <= 1'b1;
        word_r <= fifo_out_data;
      end
      // slave overrun: drop the word being read, newer one follows
      if (push_evt & slave & (rd_st_r == R_SHIFT))
      begin
        err_r <= 1'b1;
        have_r <= 1'b0;
        rd_st_r <= R_DONE;
      end
      else
      begin
        case (rd_st_r)
          R_IDLE:
          begin
            if (access & have_r)
            begin
              if (ser_s)
              begin
                rd_st_r <= R_SHIFT;
                sr_r <= word_r;
                bit_cnt_r <= 6'h00;
                half_cnt_r <= 8'h00;
                sclk_int_r <= 1'b0;
                gap_r <= 1'b0;
                gap_ph_r <= 1'b0;
                fs_act_r <= master;
              end
              else
              begin
                rd_st_r <= R_PAR;
              end
            end
          end
          R_PAR:
          begin
            // first read returns the first channel, the next one the other
            if (~access)
            begin
              rd_st_r <= R_IDLE;
              par_hi_r <= ~par_hi_r;
              if (par_hi_r)
              begin
                have_r <= 1'b0;
              end
            end
          end
          R_SHIFT:
          begin
            if (~access)
            begin
              // read abandoned: word kept, next read starts over
              rd_st_r <= R_IDLE;
              fs_act_r <= 1'b0;
              sclk_int_r <= 1'b0;
            end
            else if (master)
            begin
              half_cnt_r <= tog ? 8'h00 : half_cnt_r + 8'h01;
              if (tog & gap_r)
              begin
                // clock held one period between channels, sync inactive
                gap_ph_r <= ~gap_ph_r;
                if (gap_ph_r)
                begin
                  gap_r <= 1'b0;
                  fs_act_r <= 1'b1;
                end
              end
              else if (tog)
              begin
                sclk_int_r <= ~sclk_int_r;
                if (sclk_int_r)
                begin
                  sr_r <= {sr_r[WW-2:0], 1'b0};
                  bit_cnt_r <= cnt_inc;
                  if (cnt_inc == `DACOC_HALF_BITS)
                  begin
                    gap_r <= 1'b1;
                    fs_act_r <= 1'b0;
                  end
                  else if (cnt_inc == `DACOC_WORD_BITS)
                  begin
                    fs_act_r <= 1'b0;
                    have_r <= 1'b0;
                    rd_st_r <= R_DONE;
                  end
                end
              end
            end
            else
            begin
              // no update before the first sample: the msb stays readable
              if (upd_edge & (bit_cnt_r != 6'h00))
              begin
                sr_r <= {sr_r[WW-2:0], 1'b0};
              end
              if (smp_edge)
              begin
                bit_cnt_r <= cnt_inc;
                if (cnt_inc == `DACOC_WORD_BITS)
                begin
                  have_r <= 1'b0;
                  rd_st_r <= R_DONE;
                end
              end
            end
          end
          R_DONE:
          begin
            sclk_int_r <= 1'b0;
            if (~access)
            begin
              rd_st_r <= R_IDLE;
            end
          end
          default:
          begin
            rd_st_r <= R_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------
  // pin drive
  // --------------------------------
  reg [RES_W-1:0] d_out_nxt;
  wire fs_now = fs_act_r | (have_r & (rd_st_r == R_IDLE)); // active in first driven cycle
  reg [RES_W-1:0] d_oe_nxt;
  reg [RES_W-1:0] d_out_r;
  reg [RES_W-1:0] d_oe_r;

  // every pin is released unless select and read are both low
  always @*
  begin
    d_out_nxt = `DACOC_RST_BUS;
    d_oe_nxt = `DACOC_RST_BUS;
    if (~ser_s)
    begin
      d_out_nxt = par_hi_r ? word_r[RES_W-1:0] : word_r[WW-1:RES_W];
      d_oe_nxt = {RES_W{access}};
    end
    else
    begin
      // upper bits stay released in serial mode
      d_out_nxt[`DACOC_BIT_SDO] = sr_r[WW-1];
      d_oe_nxt[`DACOC_BIT_SDO] = access;
      d_out_nxt[`DACOC_BIT_SCLK] = sclk_int_r ^ sck_inv_s;
      d_oe_nxt[`DACOC_BIT_SCLK] = access & master;
      d_out_nxt[`DACOC_BIT_FS] = fs_now ^ fs_inv_s;
      d_oe_nxt[`DACOC_BIT_FS] = access & master;
      d_out_nxt[`DACOC_BIT_ERR] = err_r;
      d_oe_nxt[`DACOC_BIT_ERR] = access & slave;
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      d_out_r <= `DACOC_RST_BUS;
      d_oe_r <= `DACOC_RST_BUS;
    end
    else
    begin
      d_out_r <= d_out_nxt;
      d_oe_r <= d_oe_nxt;
    end
  end

  assign busy = busy_r;
  assign eoc_n = eoc_n_r;
  assign d_out = d_out_r;
  assign d_oe = d_oe_r;

endmodule // dacoc_ctrl

`default_nettype wire

// [verification/dacoc_ctrl_chk.sv]
// Purpose: port assertions, output control
// Assumes: one mclk domain, bound onto dacoc_ctrl
// Notes: pin sync adds 2-3 cycles to windows
`timescale 1ns/1ns
`default_nettype none

module dacoc_ctrl_chk #(
  parameter RES_W = 16,
  parameter CONV_CYC = 70
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // host pins
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic reset_in,
  input wire logic power_down_in,
  input wire logic impulse_mode,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic frame_sync_invert,
  // device outputs
  input wire logic busy,
  input wire logic eoc_n,
  input wire logic [RES_W-1:0] d_out,
  input wire logic [RES_W-1:0] d_oe
);
  // --------------------------------
  // busy age and properties
  // --------------------------------
  logic [9:0] age_r;
  logic [9:0] age_nxt;

  // cycles since busy rose; 10 bits also covers a stalled full buffer
  always_comb age_nxt = busy ? age_r + 10'h001 : 10'h000;
  always_ff @(posedge mclk)
  begin
    if (srst)
      age_r <= 10'h000;
    else
      age_r <= age_nxt;
  end

  default clocking cb @(posedge mclk); endclocking
  // the reset pin aborts work too
  default disable iff (srst || reset_in);

  start_busy_a:
    assert property ($fell(convert_start_n) && !busy && !power_down_in && !impulse_mode
      |-> ##[3:4] busy) else $error("start edge did not raise busy");
  eoc_pulse_a:
    assert property ($fell(eoc_n) |-> busy ##1 eoc_n) else $error("eoc pulse bad");
  eoc_time_a:
    assert property ($fell(eoc_n) |-> age_r == CONV_CYC || age_r == 2 * CONV_CYC)
      else $error("eoc at wrong time");
  busy_hold_a:
    assert property ($fell(busy) |-> age_r > 2 * CONV_CYC) else $error("busy fell early");
  bus_gate_a:
    assert property ((cs_n || rd_n) [*5] |-> d_oe == '0) else $error("bus driven unselected");
  par_width_a:
    assert property (!serial_parallel_select && d_oe != '0 |-> d_oe == '1)
      else $error("parallel bus partly driven");
  master_pins_a:
    assert property ((serial_parallel_select && !clock_source_select) [*4]
      |-> d_oe[RES_W-1:11] == '0) else $error("master mode drives spare pins");
  slave_pins_a:
    assert property ((serial_parallel_select && clock_source_select) [*4]
      |-> d_oe[RES_W-1:12] == '0 && d_oe[10:9] == 2'h0) else $error("slave drives spare pins");
  sync_start_a:
    assert property (serial_parallel_select && !clock_source_select && $rose(d_oe[10])
      |-> d_out[10] == !frame_sync_invert) else $error("frame sync polarity");
  err_pulse_a:
    assert property (serial_parallel_select && clock_source_select
      && $rose(d_out[11] && d_oe[11]) |=> !d_out[11]) else $error("flag pulse too long");
  pd_block_a:
    assert property ((power_down_in && !busy) [*6] |=> !busy) else $error("start in power-down");
endmodule // dacoc_ctrl_chk

bind dacoc_ctrl dacoc_ctrl_chk #(.RES_W(RES_W), .CONV_CYC(CONV_CYC)) u_chk (
  .mclk(mclk), .srst(srst), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
  .reset_in(reset_in), .power_down_in(power_down_in), .impulse_mode(impulse_mode),
  .serial_parallel_select(serial_parallel_select), .clock_source_select(clock_source_select),
  .frame_sync_invert(frame_sync_invert), .busy(busy), .eoc_n(eoc_n), .d_out(d_out),
  .d_oe(d_oe));

`default_nettype wire

// [verification/dacoc_host_model.sv]
// Purpose: host reading results over the parallel or serial port
// Assumes: sclk_in period is 8 mclk; outside frames it moves only in junk_clk and to its idle level before a read
// Notes: parallel and master reads wait for the device to enable the bus; slave reads take d_out[8] unchecked
`timescale 1ns/1ns
`default_nettype none

module dacoc_host_model (
  // clock
  input wire logic mclk,
  // result bus
  input wire logic [15:0] d_out,
  input wire logic [15:0] d_oe,
  // port configuration
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic serial_clock_invert,
  // strobes and serial clock
  output var logic cs_n,
  output var logic rd_n,
  output var logic sclk_in
);
  // --------------------------------
  // read tasks
  // --------------------------------
  initial
  begin
    cs_n = 1'h1;
    rd_n = 1'h1;
    sclk_in = 1'h0;
  end

  // deselect; device lets go after a few cycles
  task automatic release_bus();
    cs_n <= 1'h1;
    rd_n <= 1'h1;
    repeat (5) @(posedge mclk);
  endtask

  // edges while deselected must be ignored
  task automatic junk_clk();
    repeat (6)
    begin
      sclk_in <= ~sclk_in;
      repeat (4) @(posedge mclk);
    end
  endtask

  // one word; a short slave read stays selected
  task automatic access(input int nbits, output logic [31:0] w);
    int i;
    int k;
    logic p;
    w = 32'h0;
    i = 0;
    p = 1'h1;
    sclk_in <= serial_clock_invert;
    @(posedge mclk);
    cs_n <= 1'h0;
    rd_n <= 1'h0;
    if (!serial_parallel_select)
    begin
      for (k = 0; k < 2; k++)
      begin
        for (i = 0; i < 12 && d_oe !== 16'hffff; i++) @(posedge mclk);
        w = {w[15:0], d_out};
        release_bus();
        cs_n <= (k != 0);
        rd_n <= (k != 0);
      end
    end
    else if (!clock_source_select)
    begin
      // a bit at each internal clock rise
      for (k = 0; k < 400 && i < 32; k++)
      begin
        @(posedge mclk);
        if (d_oe[9] === 1'h1 && (d_out[9] ^ serial_clock_invert) === 1'h1 && p === 1'h0)
        begin
          w = {w[30:0], d_out[8]};
          i++;
        end
        p = d_out[9] ^ serial_clock_invert;
      end
      release_bus();
    end
    else
    begin
      repeat (6) @(posedge mclk);
      for (i = 0; i < nbits; i++)
      begin
        sclk_in <= ~serial_clock_invert;
        repeat (5) @(posedge mclk);
        w = {w[30:0], d_out[8]};
        sclk_in <= serial_clock_invert;
        repeat (3) @(posedge mclk);
      end
      if (nbits == 32)
        release_bus();
    end
  endtask
endmodule // dacoc_host_model

`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for the converter output control
// Assumes: 100 MHz mclk, default timing parameters
// Notes: expected words come from a queue filled per conversion
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic mclk, srst, convert_start_n, reset_in, power_down_in, impulse_mode;
  logic serial_parallel_select, clock_source_select, frame_sync_invert;
  logic serial_clock_invert, channel_order_sel, cs_n, rd_n, sclk_in, busy, eoc_n;
  logic [15:0] result_a, result_b, d_out, d_oe, ra, rb;
  logic [31:0] w;
  logic [31:0] exp_q[$];
  int mismatches, checked, eoc_cnt, err_cnt, eb, m, i;

  dacoc_ctrl u_dut (.mclk(mclk), .srst(srst), .convert_start_n(convert_start_n),
    .cs_n(cs_n), .rd_n(rd_n), .reset_in(reset_in), .power_down_in(power_down_in),
    .impulse_mode(impulse_mode), .serial_parallel_select(serial_parallel_select),
    .clock_source_select(clock_source_select), .frame_sync_invert(frame_sync_invert),
    .serial_clock_invert(serial_clock_invert), .channel_order_sel(channel_order_sel),
    .sclk_in(sclk_in), .result_a(result_a), .result_b(result_b), .busy(busy),
    .eoc_n(eoc_n), .d_out(d_out), .d_oe(d_oe));
  dacoc_host_model u_host (.mclk(mclk), .d_out(d_out), .d_oe(d_oe),
    .serial_parallel_select(serial_parallel_select), .clock_source_select(clock_source_select),
    .serial_clock_invert(serial_clock_invert), .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in));

  // --------------------------------
  // clock, event counters, tasks
  // --------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // count end-of-channel strobes and incomplete-read flags
  always @(posedge mclk)
  begin
    if (eoc_n === 1'h0)
      eoc_cnt++;
    if (serial_parallel_select && clock_source_select && d_oe[11] === 1'h1 && d_out[11] === 1'h1)
      err_cnt++;
  end

  task chk(input bit ok, input string what);
    checked++;
    if (!ok)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task summarize;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hold keeps the start pin low afterwards
  task automatic start_conv(input bit hold);
    int k;
    ra = 16'($urandom);
    rb = 16'($urandom);
    result_a <= ra;
    result_b <= rb;
    convert_start_n <= 1'h0;
    eb = eoc_cnt;
    repeat (2) @(posedge mclk);
    if (!hold)
      convert_start_n <= 1'h1;
    for (k = 0; k < 8 && busy !== 1'h1; k++) @(posedge mclk);
    chk(busy === 1'h1, "no busy rise");
  endtask

  // busy falling is taken as the data-ready strobe
  task automatic end_conv(input int lim);
    int k;
    for (k = 0; k < lim && busy !== 1'h0; k++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk(busy === 1'h0 && eoc_cnt - eb == 2, "no finish");
    exp_q.push_back(channel_order_sel ? {ra, rb} : {rb, ra});
  endtask

  task automatic rd_cmp();
    logic [31:0] got;
    u_host.access(32, got);
    chk(got === exp_q.pop_front(), "word mismatch");
    chk(d_oe === 16'h0000, "bus left enabled");
  endtask

  // hang guard, well past a clean run
  initial
  begin
    #300000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    {srst, convert_start_n} = 2'h3;
    {reset_in, power_down_in, impulse_mode, serial_parallel_select} = 4'h0;
    {clock_source_select, frame_sync_invert, serial_clock_invert, channel_order_sel} = 4'h0;
    {result_a, result_b} = 32'h0;
    {mismatches, checked, eoc_cnt, err_cnt} = 128'h0;
    void'($urandom(28825));
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    repeat (2) @(posedge mclk);
    chk(busy === 1'h0 && eoc_n === 1'h1 && d_oe === 16'h0000, "not idle");
    // parallel, serial master and serial slave, both polarities each
    for (m = 0; m < 6; m++)
    begin
      serial_parallel_select <= (m > 1);
      clock_source_select <= (m > 3);
      {serial_clock_invert, frame_sync_invert, channel_order_sel} <= {3{m[0]}};
      repeat (4) @(posedge mclk);
      start_conv(0);
      end_conv(400);
      if (m > 3)
        u_host.junk_clk();
      rd_cmp();
    end
    // a conversion ends during a slave read: the word in flight is lost
    start_conv(0);
    end_conv(400);
    start_conv(0);
    u_host.access(8, w);
    i = err_cnt;
    end_conv(400);
    chk(err_cnt - i == 1, "no error flag");
    u_host.release_bus();
    w = exp_q.pop_front();
    rd_cmp();
    {serial_parallel_select, clock_source_select} <= 2'h0;
    power_down_in <= 1'h1;
    repeat (4) @(posedge mclk);
    convert_start_n <= 1'h0;
    repeat (2) @(posedge mclk);
    convert_start_n <= 1'h1;
    repeat (12) @(posedge mclk);
    chk(busy === 1'h0, "pd start");
    power_down_in <= 1'h0;
    repeat (5) @(posedge mclk);
    start_conv(0);
    power_down_in <= 1'h1;
    end_conv(400);
    power_down_in <= 1'h0;
    rd_cmp();
    // impulse: held start restarts
    impulse_mode <= 1'h1;
    repeat (4) @(posedge mclk);
    start_conv(1);
    end_conv(400);
    ra = 16'($urandom);
    rb = 16'($urandom);
    {result_a, result_b} <= {ra, rb};
    eb = eoc_cnt;
    for (i = 0; i < 40 && busy !== 1'h1; i++) @(posedge mclk);
    chk(busy === 1'h1, "no restart");
    convert_start_n <= 1'h1;
    end_conv(400);
    impulse_mode <= 1'h0;
    repeat (30) @(posedge mclk);
    rd_cmp();
    rd_cmp();
    // reset pin in mid-conversion
    start_conv(0);
    repeat (20) @(posedge mclk);
    reset_in <= 1'h1;
    repeat (5) @(posedge mclk);
    reset_in <= 1'h0;
    repeat (6) @(posedge mclk);
    chk(busy === 1'h0 && eoc_n === 1'h1 && d_oe === 16'h0000, "not aborted");
    start_conv(0);
    end_conv(400);
    rd_cmp();
    // fill the buffer with no reads, then one more holds busy high
    for (i = 0; i < 17; i++)
    begin
      start_conv(0);
      end_conv(400);
    end
    start_conv(0);
    repeat (300) @(posedge mclk);
    chk(busy === 1'h1, "busy fell, full");
    rd_cmp();
    end_conv(50);
    for (i = 0; i < 17; i++)
      rd_cmp();
    summarize();
  end
endmodule // testbench

`default_nettype wire
